/* rirqc_pkg.sv */
// rirqc_pkg: constants for the host-side radio interrupt clear controller.
// assumes a 26-bit device interrupt status word and a 20 MHz system clock.
package rirqc_pkg;

	localparam int INT_W = 26;

	// device interrupt bit positions
	localparam int B_FEMPTY = 4;
	localparam int B_FFULL = 5;
	localparam int B_CCA = 8;
	localparam int B_DIV = 9;
	localparam int B_TXERR = 15;
	localparam int B_TXDONE0 = 16;
	localparam int B_RXDONE0 = 18;
	localparam int B_CRC0 = 20;
	localparam int B_TXACC0 = 22;
	localparam int B_PLL = 25;

	// bit groups
	localparam logic [INT_W-1:0] RESERVED_MASK = 26'h00000C2;
	localparam logic [INT_W-1:0] FIFO_AUTO_MASK = 26'h0000030;
	localparam logic [INT_W-1:0] TX_BLOCK_MASK = 26'h2C38000;
	localparam logic [INT_W-1:0] RX_BLOCK_MASK = 26'h20C0000;
	localparam logic [INT_W-1:0] CCA_BLOCK_MASK = 26'h0000100;

	// software register indices
	localparam logic [3:0] A_CMD = 4'h0;
	localparam logic [3:0] A_CLR = 4'h1;
	localparam logic [3:0] A_STAT = 4'h2;
	localparam logic [3:0] A_EVT = 4'h3;
	localparam logic [3:0] A_MASK = 4'h4;
	localparam logic [3:0] A_BLOCK = 4'h5;

	// command register fields
	localparam int C_TX = 0;
	localparam int C_RX = 1;
	localparam int C_CCA = 2;
	localparam int C_AUTO = 3;
	localparam logic C_AUTO_RST = 1'b0;

	// event status fields
	localparam int EVT_W = 4;
	localparam int E_CLR_DONE = 0;
	localparam int E_REFUSED = 1;
	localparam int E_CMD = 2;
	localparam int E_FIFO = 3;

	// settle time after a clear or a command, before the mirror is trusted
	localparam int CLK_NS = 50;
	localparam int SETTLE_NS = 100;
	localparam int SETTLE_W = 4;
	localparam logic [SETTLE_W-1:0] SETTLE_CYC =
		SETTLE_W'((SETTLE_NS + CLK_NS - 1) / CLK_NS);

	typedef enum logic [0:0]
	{
		ST_IDLE = 1'b0,
		ST_SETTLE = 1'b1
	} rirqc_st_t;

endpackage

/* rirqc_gate.sv */
// rirqc_gate: decides which pending clear requests may go to the device now.
// assumes status is the registered mirror of the device interrupt word.
`timescale 1ns/1ns
`default_nettype none
module rirqc_gate
	import rirqc_pkg::*;
(
	input wire logic [rirqc_pkg::INT_W-1:0] status,
	input wire logic [rirqc_pkg::INT_W-1:0] pend,
	input wire logic rx_busy,
	input wire logic tx_busy,
	input wire logic [1:0] tx_done_seen,
	output logic [rirqc_pkg::INT_W-1:0] allow,
	output logic [rirqc_pkg::INT_W-1:0] refuse
);
	import rirqc_pkg::*;

	logic [INT_W-1:0] cand;
	logic [1:0] txacc_ok;
	logic div_ok;

	// a bit not raised cannot be cleared; drop it
	assign cand = pend & status & ~RESERVED_MASK;
	assign refuse = pend & (~status | RESERVED_MASK);

	genvar i;
	generate
		for (i = 0; i < 2; i++)
		begin : g_fifo
			// accept flag only after its completion, never while sending
			assign txacc_ok[i] = cand[B_TXACC0+i] & tx_done_seen[i] &
				~tx_busy;
		end
	endgenerate

	// diversity flag waits for an rx completion, never mid-reception
	assign div_ok = cand[B_DIV] & ~rx_busy &
		(status[B_RXDONE0] | status[B_RXDONE0+1]);

	always_comb
	begin
		allow = cand;
		allow[B_DIV] = div_ok;
		allow[B_TXACC0+1:B_TXACC0] = txacc_ok;
		if (div_ok)
		begin
			// rx completion leaves together with the diversity flag
			allow[B_RXDONE0+1:B_RXDONE0] =
				status[B_RXDONE0+1:B_RXDONE0];
		end
	end

endmodule // rirqc_gate
`default_nettype wire

/* rirqc_host.sv */
// rirqc_host: host-side controller that clears radio interrupt bits safely
// and holds back tx, rx and cca starts until the flags they need are clear.
// assumes the device status word and radio state inputs are synchronous to
// ref_clk, and that a one-cycle clear strobe clears the named bits.
//
// Overview of operation
// - a bit is cleared only once the device has raised it.
// - fifo-empty is cleared before the next empty trigger.
// - fifo-full is cleared before the next full trigger.
// - cca completion is cleared before the next cca starts.
// - diversity completion is cleared only with a raised rx completion.
// - diversity completion is never cleared while receiving.
// - tx error and tx completion flags are clear before a transmission.
// - rx completion flags are clear before a reception starts.
// - tx accept flags are cleared only after their tx completion.
// - tx accept flags are never cleared while transmitting.
// - pll unlock is clear before any transmission or reception.
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module rirqc_host
	import rirqc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [3:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	output logic irq,
	input wire logic [rirqc_pkg::INT_W-1:0] dev_int_status,
	input wire logic dev_radio_rx,
	input wire logic dev_radio_tx,
	output logic [rirqc_pkg::INT_W-1:0] dev_clr_bits,
	output logic dev_clr_stb,
	output logic dev_tx_start,
	output logic dev_rx_start,
	output logic dev_cca_start
);
	import rirqc_pkg::*;

	typedef struct packed
	{
		rirqc_st_t st;
		logic [INT_W-1:0] stat;
		logic [INT_W-1:0] pend;
		logic [2:0] cmd_pend;
		logic auto_fifo;
		logic [EVT_W-1:0] evt;
		logic [EVT_W-1:0] evt_mask;
		logic [1:0] tx_done_seen;
		logic [SETTLE_W-1:0] cnt;
		logic [INT_W-1:0] clr_bits;
		logic clr_stb;
		logic tx_start;
		logic rx_start;
		logic cca_start;
		logic [31:0] rdata;
		logic irq;
	} rirqc_state_t;

	rirqc_state_t r;
	rirqc_state_t next_r;

	logic [INT_W-1:0] allow;
	logic [INT_W-1:0] refuse;
	logic tx_blk;
	logic rx_blk;
	logic cca_blk;

	rirqc_gate u_gate
	(
		.status(r.stat),
		.pend(r.pend),
		.rx_busy(dev_radio_rx),
		.tx_busy(dev_radio_tx),
		.tx_done_seen(r.tx_done_seen),
		.allow(allow),
		.refuse(refuse)
	);

	assign tx_blk = |(r.stat & TX_BLOCK_MASK);
	assign rx_blk = |(r.stat & RX_BLOCK_MASK);
	assign cca_blk = |(r.stat & CCA_BLOCK_MASK);

	always_comb
	begin
		logic [EVT_W-1:0] evt_set;
		logic [INT_W-1:0] issued;
		logic [INT_W-1:0] add;
		logic [2:0] cmd_add;
		logic [INT_W-1:0] fifo_add;
		evt_set = '0;
		issued = '0;
		add = '0;
		cmd_add = '0;
		fifo_add = '0;
		next_r = r;
		next_r.stat = dev_int_status;
		next_r.clr_stb = 1'b0;
		next_r.tx_start = 1'b0;
		next_r.rx_start = 1'b0;
		next_r.cca_start = 1'b0;

		if (sw_wr && sw_addr == A_CLR)
		begin
			add = sw_wdata[INT_W-1:0];
		end
		if (sw_wr && sw_addr == A_CMD)
		begin
			cmd_add = sw_wdata[C_CCA:C_TX];
			next_r.auto_fifo = sw_wdata[C_AUTO];
		end
		if (sw_wr && sw_addr == A_MASK)
		begin
			next_r.evt_mask = sw_wdata[EVT_W-1:0];
		end
		// fifo level flags are re-armed at once so the next trigger shows;
		// idle only, as the lagging mirror still shows a bit just cleared
		fifo_add = r.stat & FIFO_AUTO_MASK & ~r.pend;
		if (r.auto_fifo && r.st == ST_IDLE && fifo_add != '0)
		begin
			add = add | fifo_add;
			evt_set[E_FIFO] = 1'b1;
		end
		if (refuse != '0)
		begin
			evt_set[E_REFUSED] = 1'b1;
		end

		case (r.st)
			ST_IDLE:
			begin
				if (allow != '0)
				begin
					issued = allow;
					next_r.clr_bits = allow;
					next_r.clr_stb = 1'b1;
					next_r.cnt = SETTLE_CYC;
					next_r.st = ST_SETTLE;
					evt_set[E_CLR_DONE] = 1'b1;
				end
				else if (r.cmd_pend[C_TX] && !tx_blk)
				begin
					next_r.tx_start = 1'b1;
					next_r.cmd_pend[C_TX] = 1'b0;
					next_r.cnt = SETTLE_CYC;
					next_r.st = ST_SETTLE;
					evt_set[E_CMD] = 1'b1;
				end
				else if (r.cmd_pend[C_RX] && !rx_blk)
				begin
					next_r.rx_start = 1'b1;
					next_r.cmd_pend[C_RX] = 1'b0;
					next_r.cnt = SETTLE_CYC;
					next_r.st = ST_SETTLE;
					evt_set[E_CMD] = 1'b1;
				end
				else if (r.cmd_pend[C_CCA] && !cca_blk)
				begin
					next_r.cca_start = 1'b1;
					next_r.cmd_pend[C_CCA] = 1'b0;
					next_r.cnt = SETTLE_CYC;
					next_r.st = ST_SETTLE;
					evt_set[E_CMD] = 1'b1;
				end
			end
			ST_SETTLE:
			begin
				// mirror lags the device; wait before trusting it again
				next_r.cnt = r.cnt - SETTLE_W'(1);
				if (r.cnt <= SETTLE_W'(1))
				begin
					next_r.st = ST_IDLE;
				end
			end
			default:
			begin
				next_r.st = ST_IDLE;
			end
		endcase

		next_r.pend = (r.pend & ~refuse & ~issued) | add;
		next_r.cmd_pend = next_r.cmd_pend | cmd_add;

		// completion seen arms the accept clear; a new completion wins
		next_r.tx_done_seen = (r.tx_done_seen &
			~issued[B_TXACC0+1:B_TXACC0]) |
			r.stat[B_TXDONE0+1:B_TXDONE0];

		// read clears the event bits, but a same-cycle event survives
		if (sw_rd && sw_addr == A_EVT)
		begin
			next_r.evt = evt_set;
		end
		else
		begin
			next_r.evt = r.evt | evt_set;
		end

		next_r.rdata = '0;
		if (sw_rd)
		begin
			case (sw_addr)
				A_CMD: next_r.rdata = {28'h0, r.auto_fifo, r.cmd_pend};
				A_CLR: next_r.rdata = {{(32-INT_W){1'b0}}, r.pend};
				A_STAT: next_r.rdata = {{(32-INT_W){1'b0}}, r.stat};
				A_EVT: next_r.rdata = {{(32-EVT_W){1'b0}}, r.evt};
				A_MASK: next_r.rdata = {{(32-EVT_W){1'b0}}, r.evt_mask};
				A_BLOCK: next_r.rdata = {29'h0, cca_blk, rx_blk, tx_blk};
				default: next_r.rdata = '0;
			endcase
		end

		next_r.irq = |(next_r.evt & next_r.evt_mask);
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			r <= '0;
			r.auto_fifo <= C_AUTO_RST;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign sw_rdata = r.rdata;
	assign irq = r.irq;
	assign dev_clr_bits = r.clr_bits;
	assign dev_clr_stb = r.clr_stb;
	assign dev_tx_start = r.tx_start;
	assign dev_rx_start = r.rx_start;
	assign dev_cca_start = r.cca_start;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_clr_only_raised:
	assert property (dev_clr_stb |->
		(dev_clr_bits & ~$past(r.stat)) == '0)
	else $error("clear strobe names a bit that was not raised");

	a_div_with_rx:
	assert property (dev_clr_stb && dev_clr_bits[B_DIV] |->
		dev_clr_bits[B_RXDONE0+1:B_RXDONE0] != 2'h0)
	else $error("diversity flag cleared without rx completion");

	a_div_not_rx:
	assert property (dev_clr_stb && dev_clr_bits[B_DIV] |->
		!$past(dev_radio_rx))
	else $error("diversity flag cleared while receiving");

	a_txacc_not_tx:
	assert property (dev_clr_stb &&
		dev_clr_bits[B_TXACC0+1:B_TXACC0] != 2'h0 |->
		!$past(dev_radio_tx))
	else $error("tx accept flag cleared while transmitting");

	a_txacc_after_done:
	assert property (dev_clr_stb && dev_clr_bits[B_TXACC0] |->
		$past(r.tx_done_seen[0]))
	else $error("tx accept flag cleared before tx completion");

	a_tx_start_gate:
	assert property (dev_tx_start |->
		($past(r.stat) & TX_BLOCK_MASK) == '0)
	else $error("transmission started with tx flags pending");

	a_rx_start_gate:
	assert property (dev_rx_start |->
		($past(r.stat) & RX_BLOCK_MASK) == '0)
	else $error("reception started with rx flags pending");

	a_cca_start_gate:
	assert property (dev_cca_start |-> !$past(r.stat[B_CCA]))
	else $error("cca started with cca completion pending");

	a_evt_read_keep:
	assert property (sw_rd && sw_addr == A_EVT && refuse != '0 |=>
		r.evt[E_REFUSED])
	else $error("event lost during status read");

	a_strobe_spacing:
	assert property (dev_clr_stb |=> !dev_clr_stb [*2])
	else $error("clear strobes too close together");

	a_clr_no_reserved:
	assert property (dev_clr_stb |-> (dev_clr_bits & RESERVED_MASK) == '0)
	else $error("clear strobe names a reserved bit");

	a_div_rx_pair:
	assert property (dev_clr_stb && dev_clr_bits[B_DIV] |->
		dev_clr_bits[B_RXDONE0+1:B_RXDONE0] ==
		$past(r.stat[B_RXDONE0+1:B_RXDONE0]))
	else $error("diversity flag cleared apart from its rx completion");

	a_txacc1_after_done:
	assert property (dev_clr_stb && dev_clr_bits[B_TXACC0+1] |->
		$past(r.tx_done_seen[1]))
	else $error("tx accept flag 1 cleared before tx completion");

	a_pll_start_gate:
	assert property (dev_tx_start || dev_rx_start |->
		!$past(r.stat[B_PLL]))
	else $error("radio started with pll unlock pending");

	a_fifo_rearm:
	assert property (r.auto_fifo && r.st == ST_IDLE &&
		r.stat[B_FEMPTY] && !r.pend[B_FEMPTY] |->
		##[2:4] (dev_clr_stb && dev_clr_bits[B_FEMPTY]))
	else $error("raised empty flag not re-armed in time");

	a_one_action:
	assert property ($onehot0({dev_clr_stb, dev_tx_start, dev_rx_start,
		dev_cca_start}))
	else $error("more than one device action in a cycle");

	a_start_spacing:
	assert property (dev_tx_start || dev_rx_start || dev_cca_start |=>
		!(dev_clr_stb || dev_tx_start || dev_rx_start || dev_cca_start) [*2])
	else $error("device action too soon after a start");

	a_rdata_idle:
	assert property (!$past(sw_rd) |-> sw_rdata == '0)
	else $error("read data shown outside its cycle");

	c_tx_start: cover property (dev_tx_start);
	c_div_clear: cover property (dev_clr_stb && dev_clr_bits[B_DIV]);
	c_cca_start: cover property (dev_cca_start);
	c_fifo_auto: cover property (r.evt[E_FIFO] && irq);

endmodule // rirqc_host
`default_nettype wire

/* rirqc_dev.sv */
// rirqc_dev: behavioural radio device that holds the interrupt status word.
// assumes the bench drives events, faults and radio state after ref_clk edges.
`timescale 1ns/1ns
`default_nettype none
module rirqc_dev
	import rirqc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [rirqc_pkg::INT_W-1:0] ev,
	input wire logic rx_fault,
	input wire logic tx_fault,
	input wire logic [rirqc_pkg::INT_W-1:0] clr_bits,
	input wire logic clr_stb,
	input wire logic radio_rx,
	input wire logic radio_tx,
	input wire logic tx_start,
	input wire logic rx_start,
	input wire logic cca_start,
	output logic [rirqc_pkg::INT_W-1:0] int_status,
	output logic cca_result,
	output logic [1:0] crc_result,
	output logic [7:0] viol
);
	import rirqc_pkg::*;

	logic [INT_W-1:0] clr, set;
	logic bad;
	assign clr = clr_stb ? clr_bits : '0;
	assign set = (ev | (INT_W'(rx_fault) << (B_TXERR - 1))
		| (INT_W'(tx_fault) << B_TXERR)) & ~RESERVED_MASK;
	// host misuse is counted, not refused, so the bench can see it
	assign bad = (clr & ~int_status) != '0
		|| (clr[B_DIV] && (radio_rx || clr[B_RXDONE0+:2] == 2'h0))
		|| (clr[B_TXACC0+:2] != 2'h0 && radio_tx)
		|| ((clr[B_TXACC0+:2] & ~int_status[B_TXDONE0+:2]) != 2'h0)
		|| ((set & int_status & FIFO_AUTO_MASK) != '0)
		|| (tx_start && (int_status & TX_BLOCK_MASK) != '0)
		|| (rx_start && (int_status & RX_BLOCK_MASK) != '0)
		|| (cca_start && int_status[B_CCA]);
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			int_status <= '0;
			cca_result <= 1'b0;
			crc_result <= 2'h0;
			viol <= 8'h00;
		end
		else
		begin
			// a fresh event outranks a clear in the same cycle
			int_status <= (int_status & ~clr) | set;
			cca_result <= (cca_result && !clr[B_CCA]) || set[B_CCA];
			crc_result <= (crc_result & ~clr[B_CRC0+:2]) | set[B_CRC0+:2];
			viol <= viol + 8'(bad);
		end
	end
endmodule // rirqc_dev
`default_nettype wire

/* rirqc_host_tb_top.sv */
// rirqc_host_tb_top: register-level bench for the interrupt clear controller.
// assumes rirqc_dev stands in for the radio on the device link.
`timescale 1ns/1ns
`default_nettype none
module rirqc_host_tb_top;
	import rirqc_pkg::*;
	logic ref_clk, rst_n, sw_wr, sw_rd, irq, rx, tx, rxf, txf;
	logic clr_stb, txs, rxs, ccas, cca_res;
	logic [3:0] sw_addr;
	logic [31:0] sw_wdata, sw_rdata, v;
	logic [INT_W-1:0] st, ev, clr_bits;
	logic [1:0] crc;
	logic [7:0] viol;
	int failures = 0, tests_run = 0, n_tx = 0, n_cca = 0, n_rx = 0;
	rirqc_host u_rirqc_host(.ref_clk, .rst_n, .sw_addr, .sw_wdata, .sw_wr,
		.sw_rd, .sw_rdata, .irq, .dev_int_status(st), .dev_radio_rx(rx),
		.dev_radio_tx(tx), .dev_clr_bits(clr_bits), .dev_clr_stb(clr_stb),
		.dev_tx_start(txs), .dev_rx_start(rxs), .dev_cca_start(ccas));
	rirqc_dev u_rirqc_dev(.ref_clk, .rst_n, .ev, .rx_fault(rxf),
		.tx_fault(txf), .clr_bits, .clr_stb, .radio_rx(rx), .radio_tx(tx),
		.tx_start(txs), .rx_start(rxs), .cca_start(ccas), .int_status(st),
		.cca_result(cca_res), .crc_result(crc), .viol);
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		if (txs === 1'b1)
			n_tx++;
		if (ccas === 1'b1)
			n_cca++;
		if (rxs === 1'b1)
			n_rx++;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge ref_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge ref_clk);
		sw_rd <= 1'b0;
		@(posedge ref_clk);
		v = sw_rdata;
	endtask
	task automatic pulse(input logic [INT_W-1:0] b);
		@(posedge ref_clk);
		ev <= b;
		@(posedge ref_clk);
		ev <= '0;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_sim;
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		cyc(20000);
		failures++;
		end_sim;
	end
	initial
	begin
		{sw_wr, sw_rd, rx, tx, rxf, txf, rst_n} = 7'h00;
		sw_addr = 4'h0;
		sw_wdata = 32'h0;
		ev = '0;
		cyc(5);
		rst_n <= 1'b1;
		rd(A_EVT);
		chk("evt reset", 32'h0, v);
		rd(A_MASK);
		chk("mask reset", 32'h0, v);
		pulse(26'h0000001);
		cyc(2);
		rd(A_STAT);
		chk("stat mirror", 32'h1, v);
		chk("irq masked", 32'h0, 32'(irq));
		wr(A_CLR, 32'h1);
		cyc(6);
		chk("bit0 cleared", 32'h0, {6'h00, st});
		rd(A_EVT);
		chk("clear event", 32'h1, v);
		// bit 3 never raised: the controller must drop the request
		wr(A_CLR, 32'h8);
		// read falls in the very cycle of the refusal, which must survive
		sw_addr <= A_EVT;
		sw_rd <= 1'b1;
		@(posedge ref_clk);
		sw_rd <= 1'b0;
		@(posedge ref_clk);
		chk("evt in refusal", 32'h0, sw_rdata);
		rd(A_EVT);
		chk("refused", 32'h2, v);
		pulse(26'h00000C2);
		cyc(2);
		chk("reserved", 32'h0, {6'h00, st});
		wr(A_CMD, 32'h8);
		pulse(26'h0000010);
		cyc(6);
		chk("empty rearm", 32'h0, {6'h00, st});
		pulse(26'h0000020);
		cyc(6);
		chk("full rearm", 32'h0, {6'h00, st});
		rd(A_EVT);
		chk("rearm event", 32'h9, v);
		wr(A_CMD, 32'h0);
		pulse(26'h0000100);
		cyc(2);
		wr(A_CMD, 32'h4);
		cyc(6);
		rd(A_BLOCK);
		chk("cca blocked", 32'h4, v);
		chk("cca held", 32'h0, 32'(n_cca));
		wr(A_CLR, 32'h100);
		cyc(8);
		chk("cca result", 32'h0, 32'(cca_res));
		chk("cca started", 32'h1, 32'(n_cca));
		rx <= 1'b1;
		pulse(26'h0000200);
		wr(A_CLR, 32'h200);
		cyc(6);
		chk("div in rx", 32'h200, {6'h00, st});
		rx <= 1'b0;
		cyc(6);
		chk("div alone", 32'h200, {6'h00, st});
		pulse(26'h0040000);
		cyc(8);
		chk("div pair", 32'h0, {6'h00, st});
		pulse(26'h2518000);
		wr(A_CMD, 32'h1);
		cyc(4);
		rd(A_BLOCK);
		chk("tx rx blocked", 32'h3, v);
		tx <= 1'b1;
		wr(A_CLR, 32'h400000);
		cyc(6);
		chk("acc in tx", 32'h2518000, {6'h00, st});
		chk("tx held", 32'h0, 32'(n_tx));
		tx <= 1'b0;
		wr(A_CLR, 32'h2118000);
		cyc(12);
		chk("tx flags", 32'h0, {6'h00, st});
		chk("crc result", 32'h0, 32'(crc));
		chk("tx started", 32'h1, 32'(n_tx));
		pulse(26'h0080000);
		wr(A_CMD, 32'h2);
		rd(A_CMD);
		chk("rx pending", 32'h2, v);
		chk("rx held", 32'h0, 32'(n_rx));
		wr(A_CLR, 32'h80000);
		cyc(10);
		chk("rx started", 32'h1, 32'(n_rx));
		rd(A_EVT);
		wr(A_MASK, 32'h1);
		pulse(26'h0000001);
		wr(A_CLR, 32'h1);
		cyc(6);
		chk("irq set", 32'h1, 32'(irq));
		rd(A_EVT);
		cyc(2);
		chk("irq read clear", 32'h0, 32'(irq));
		@(posedge ref_clk);
		{rxf, txf} <= 2'h3;
		@(posedge ref_clk);
		{rxf, txf} <= 2'h0;
		cyc(2);
		chk("fifo faults", 32'hC000, {6'h00, st});
		chk("host misuse", 32'h0, 32'(viol));
		end_sim;
	end
endmodule // rirqc_host_tb_top
`default_nettype wire
